//--- hw/phy_event_pkg.sv
/*
 * Package for the event flag and receive error tally block: register
 * indices, field positions, reset values.
 * Assumes a 32-bit Avalon-MM slave with word addresses equal to index.
 */
package phy_event_pkg;

  // ------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [7:0] EVENT_FLAGS_TWO_IDX     = 8'h13;
  localparam logic [7:0] RECEIVE_ERROR_TALLY_IDX = 8'h15;
  localparam logic [7:0] FLAGS_ONE_IDX           = 8'h12;
  localparam logic [7:0] LOOP_CTRL_IDX           = 8'h16;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int UNDER_VOLT_BIT = 15;
  localparam int OVER_VOLT_BIT  = 14;
  localparam int SLEEP_BIT      = 10;
  localparam int POL_BIT        = 9;
  localparam int JABBER_BIT     = 8;
  localparam int EN_OFFSET      = 8;
  localparam int HALF_FULL_BIT  = 8;
  localparam int HALF_FULL_EN   = 0;
  localparam int LOOP_BIT       = 0;

  // writable enable bits of the second flag register (bit 3 reserved)
  localparam logic [7:0]  ENABLE_MASK   = 8'hF7;
  localparam logic [15:0] FLAGS_RESET   = 16'h0000;
  localparam logic [15:0] TALLY_RESET   = 16'h0000;
  localparam logic [15:0] TALLY_MAX     = 16'hFFFF;
  localparam logic [15:0] TALLY_HALF    = 16'h7FFF;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage

//--- hw/phy_event_flags.sv
/*
 * Latched PHY event flags with per-flag enables, a saturating
 * clear-on-read receive error tally and a combined interrupt output.
 * Assumes an Avalon-MM slave; event inputs are synchronous to ref_clk.
 */
// Implementation choice: the Avalon-MM slave port.
// Function
// RQ1: bit 15 latches an under-voltage detection until cleared.
// RQ2: bit 14 latches an over-voltage detection until cleared.
// RQ3: bit 10 latches any change of sleep state and stays zero otherwise.
// RQ4: bit 9 latches each automatic receive polarity swap made in slave role.
// RQ5: bit 8 latches a jabber detection and reads zero if none was seen.
// RQ6: enable bits 7,6,5,4,2,1,0 are read/write, reset to zero, and 1 enables.
// RQ7: the 16-bit tally counts each invalid symbol while carrier and data valid hold.
// RQ8: no counting happens while mac_side_interface loopback is active.
// RQ9: the tally saturates at 0xFFFF and never wraps.
// RQ10: the tally rising above 0x7FFF raises a half-full event.
// RQ11: any read of the tally clears it to zero.
// RQ12: reading a flag register clears its latched flags.
// RQ13: the half-full event sets bit 8 of the first flag register, enabled by bit 0.
// RQ14: the interrupt output is high when any set flag has its enable set.
// RQ15: status bits 13 to 11 read zero and enable bit 3 has no effect.
`timescale 1ns/1ps
module phy_event_flags
  import phy_event_pkg::*;
#(
  parameter int TALLY_WIDTH = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        underVoltDetect,
  input  wire logic        overVoltDetect,
  input  wire logic        sleepMode,
  input  wire logic        slaveRole,
  input  wire logic        polaritySwap,
  input  wire logic        jabberDetect,
  input  wire logic        carrierValid,
  input  wire logic        rxDataValid,
  input  wire logic        invalidSymbol,
  output logic             interruptOut
);

  // elaboration check: tally logic serves only the 16-bit width
  if (TALLY_WIDTH != 16) begin : g_bad_width
    $error("TALLY_WIDTH must be 16");
  end

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rstSync1;
  logic rstSync2;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_t;

  bus_state_t busState;
  bus_state_t next_busState;

  wire request   = read | write;
  wire answering = (busState == BUS_DONE);
  wire hitFlags2 = (address == EVENT_FLAGS_TWO_IDX);
  wire hitTally  = (address == RECEIVE_ERROR_TALLY_IDX);
  wire hitFlags1 = (address == FLAGS_ONE_IDX);
  wire hitLoop   = (address == LOOP_CTRL_IDX);
  wire accept    = request & answering;
  wire readF2    = accept & read & hitFlags2;
  wire readT     = accept & read & hitTally;
  wire readF1    = accept & read & hitFlags1;
  wire writeF2   = accept & write & hitFlags2;
  wire writeF1   = accept & write & hitFlags1;
  wire writeLoop = accept & write & hitLoop;

  // one wait cycle, then answer with data registered in the wait cycle
  always_comb begin
    case (busState)
      BUS_IDLE: next_busState = request ? BUS_DONE : BUS_IDLE;
      BUS_DONE: next_busState = BUS_IDLE;
      default:  next_busState = BUS_IDLE;
    endcase
  end

  assign waitrequest = ~answering;

  always_ff @(posedge ref_clk or negedge rstSync2) begin
    if (!rstSync2) begin
      busState <= BUS_IDLE;
    end else begin
      busState <= next_busState;
    end
  end

  // ------------------------------------------------------------
  // event sources
  // ------------------------------------------------------------
  logic sleepPrev;
  logic [TALLY_WIDTH-1:0] tally;
  logic loopActive;

  wire sleepChange = sleepMode ^ sleepPrev;            // see RQ3
  wire polEvent    = polaritySwap & slaveRole;         // see RQ4
  wire countEvent  = carrierValid & rxDataValid & invalidSymbol
                     & ~loopActive;                     // see RQ7 see RQ8
  wire tallyFull   = (tally == TALLY_MAX);
  wire [TALLY_WIDTH-1:0] tallyInc = tally + 16'h0001;
  wire halfEvent   = countEvent & (tally == TALLY_HALF); // see RQ10

  wire [4:0] eventVec = {underVoltDetect, overVoltDetect, sleepChange,
                         polEvent, jabberDetect};

  // ------------------------------------------------------------
  // latched flags, set wins over clear-on-read
  // ------------------------------------------------------------
  logic [15:0] flagBits;
  logic [4:0]  flagLatch;
  logic [7:0]  enables2;
  logic        halfFlag;
  logic        halfEnable;

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_flag
      always_ff @(posedge ref_clk or negedge rstSync2) begin
        if (!rstSync2) begin
          flagLatch[g] <= 1'b0;
        end else if (eventVec[g]) begin
          flagLatch[g] <= 1'b1;                        // see RQ1 see RQ2 see RQ5
        end else if (readF2) begin
          flagLatch[g] <= 1'b0;                        // see RQ12
        end
      end
    end
  endgenerate

  // reserved and enable positions of the status half are constant zero
  assign flagBits = {flagLatch[4:3], 3'h0, flagLatch[2:0], 8'h00}; // see RQ15

  always_ff @(posedge ref_clk or negedge rstSync2) begin
    if (!rstSync2) begin
      enables2   <= FLAGS_RESET[7:0];
      halfFlag   <= 1'b0;
      halfEnable <= 1'b0;
      sleepPrev  <= 1'b0;
      loopActive <= 1'b0;
      tally      <= TALLY_RESET;
    end else begin
      sleepPrev <= sleepMode;
      if (writeF2) begin
        enables2 <= writedata[7:0] & ENABLE_MASK;      // see RQ6 see RQ15
      end
      if (writeF1) begin
        halfEnable <= writedata[HALF_FULL_EN];
      end
      if (writeLoop) begin
        loopActive <= writedata[LOOP_BIT];
      end
      if (halfEvent) begin
        halfFlag <= 1'b1;                              // see RQ13
      end else if (readF1) begin
        halfFlag <= 1'b0;
      end
      if (readT) begin
        tally <= TALLY_RESET;                          // see RQ11
      end else if (countEvent && !tallyFull) begin
        tally <= tallyInc;                             // see RQ9
      end
    end
  end

  // ------------------------------------------------------------
  // read data and interrupt
  // ------------------------------------------------------------
  wire [15:0] flags2Word = {flagBits[15:8], enables2};
  wire [15:0] flags1Word = {7'h00, halfFlag, 7'h00, halfEnable};
  wire [15:0] loopWord   = {15'h0000, loopActive};
  wire [15:0] readWord   = hitFlags2 ? flags2Word :
                           hitTally  ? tally      :
                           hitFlags1 ? flags1Word :
                           hitLoop   ? loopWord   : UNMAPPED_DATA[15:0];

  wire [4:0] pending = {flagBits[UNDER_VOLT_BIT] & enables2[UNDER_VOLT_BIT-EN_OFFSET],
                        flagBits[OVER_VOLT_BIT]  & enables2[OVER_VOLT_BIT-EN_OFFSET],
                        flagBits[SLEEP_BIT]      & enables2[SLEEP_BIT-EN_OFFSET],
                        flagBits[POL_BIT]        & enables2[POL_BIT-EN_OFFSET],
                        flagBits[JABBER_BIT]     & enables2[JABBER_BIT-EN_OFFSET]};

  always_ff @(posedge ref_clk or negedge rstSync2) begin
    if (!rstSync2) begin
      readdata     <= UNMAPPED_DATA;
      interruptOut <= 1'b0;
    end else begin
      readdata     <= {16'h0000, readWord};
      interruptOut <= (|pending) | (halfFlag & halfEnable); // see RQ14
    end
  end

endmodule

//--- verif/phy_event_flags_asserts.sv
/* Checker for phy_event_flags: bus answer, latched flags, tally clear, interrupt hold.
   Assumes only the ports of phy_event_flags; bound at the foot of this file. */
`timescale 1ns/1ps
module phy_event_flags_asserts (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        underVoltDetect,
  input wire logic        overVoltDetect,
  input wire logic        slaveRole,
  input wire logic        polaritySwap,
  input wire logic        jabberDetect,
  input wire logic        carrierValid,
  input wire logic        rxDataValid,
  input wire logic        invalidSymbol,
  input wire logic        interruptOut
);
  wire quiet = !(carrierValid && rxDataValid && invalidSymbol);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence flagRd; read && address == 8'h13 && waitrequest; endsequence
  sequence tallyDone; quiet && read && address == 8'h15 && !waitrequest; endsequence
  property latched(ev, int b); ev ##1 !read ##1 flagRd |=> readdata[b]; endproperty
  AST_UNDER_VOLT: assert property (latched(underVoltDetect, 15))
    else $error("under-voltage flag not latched");
  AST_OVER_VOLT: assert property (latched(overVoltDetect, 14))
    else $error("over-voltage flag not latched");
  AST_POL_SWAP: assert property (latched(polaritySwap && slaveRole, 9))
    else $error("polarity flag not latched");
  AST_JABBER: assert property (latched(jabberDetect, 8))
    else $error("jabber flag not latched");
  AST_TALLY_CLEAR: assert property (tallyDone ##1 (quiet && !read) ##1
    (quiet && read && address == 8'h15) |=> readdata == 32'h0) else $error("tally not cleared");
  AST_IRQ_HOLD: assert property (interruptOut && waitrequest && $past(waitrequest)
    |=> interruptOut) else $error("interrupt dropped without access");
  AST_RESERVED_ZERO: assert property (read && address == 8'h13 && !waitrequest
    |-> readdata[31:16] == 16'h0 && readdata[13:11] == 3'h0 && !readdata[3])
    else $error("reserved bits not zero");
  AST_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer after one wait cycle");
endmodule
bind phy_event_flags phy_event_flags_asserts chk_i (.ref_clk, .rstn, .address, .read,
  .write, .readdata, .waitrequest, .underVoltDetect, .overVoltDetect, .slaveRole,
  .polaritySwap, .jabberDetect, .carrierValid, .rxDataValid, .invalidSymbol, .interruptOut);

//--- verif/phy_event_flags_tb_top.sv
/* Bench for phy_event_flags: flags, enables and tally over Avalon-MM.
   Assumes the package and the bound checker are compiled before it. */
`timescale 1ns/1ps
module phy_event_flags_tb_top;
  import phy_event_pkg::*;
  logic        ref_clk = 0, rstn = 0, read = 0, write = 0, sleepMode = 0, slaveRole = 1;
  logic        carrierValid = 0, rxDataValid = 0, invalidSymbol = 0, waitrequest, interruptOut;
  logic [4:0]  ev = 5'h00;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata, rd;
  wire  [31:0] irq = {31'h0, interruptOut};
  int          err_count = 0, tests_run = 0, cycles = 0;
  always #20 ref_clk = ~ref_clk;
  phy_event_flags dut (.ref_clk, .rstn, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .underVoltDetect(ev[4]), .overVoltDetect(ev[3]), .sleepMode, .slaveRole,
    .polaritySwap(ev[1]), .jabberDetect(ev[0]), .carrierValid, .rxDataValid, .invalidSymbol,
    .interruptOut);
  task results();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 75000) begin
      err_count++;
      results();
    end
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task bus(input logic rdn, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    address <= a;
    read <= rdn;
    write <= !rdn;
    writedata <= wd;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0);
    chk(what, rd, exp);
  endtask
  task pulse(input int k);
    if (k == 2) sleepMode <= !sleepMode;
    else ev[k] <= 1'b1;
    @(posedge ref_clk);
    ev <= 5'h00;
  endtask
  task count(input int n);
    rxDataValid <= 1'b1;
    repeat (n) @(posedge ref_clk);
    rxDataValid <= 1'b0;
  endtask
  task test_regs();
    rdchk("flags reset", 8'h13, 32'h0);
    rdchk("tally reset", 8'h15, 32'h0);
    bus(1'b0, 8'h13, 32'hFFFF);
    rdchk("enables", 8'h13, 32'h00F7);
    bus(1'b0, 8'h40, 32'hFFFF);
    rdchk("unmapped", 8'h40, 32'h0);
    $display("register test done");
  endtask
  task test_flags();
    int b;
    slaveRole <= 1'b0;
    pulse(1);
    rdchk("swap outside slave role", 8'h13, 32'h00F7);
    slaveRole <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      b = (k < 3) ? 8 + k : 11 + k;
      for (int e = 0; e < 2; e++) begin
        bus(1'b0, 8'h13, 32'(e) << (b - 8));
        pulse(k);
        repeat (3) @(posedge ref_clk);
        chk("interrupt", irq, 32'(e));
        rdchk("flags", 8'h13, (32'h1 << b) | (32'(e) << (b - 8)));
        rdchk("flags cleared", 8'h13, 32'(e) << (b - 8));
      end
    end
    $display("flag test done");
  endtask
  task test_tally();
    carrierValid <= 1'b1;
    invalidSymbol <= 1'b1;
    bus(1'b0, 8'h16, 32'h1);
    count(10);
    rdchk("loopback count", 8'h15, 32'h0);
    bus(1'b0, 8'h16, 32'h0);
    repeat (4) @(posedge ref_clk);
    count(7);
    rdchk("tally", 8'h15, 32'h7);
    rdchk("tally cleared", 8'h15, 32'h0);
    bus(1'b0, 8'h12, 32'h1);
    count(32'h7FFF);
    repeat (3) @(posedge ref_clk);
    chk("below half", irq, 32'h0);
    count(1);
    repeat (3) @(posedge ref_clk);
    chk("half full", irq, 32'h1);
    count(32'h8005);
    rdchk("saturated", 8'h15, 32'hFFFF);
    rdchk("half flag", 8'h12, 32'h0101);
    repeat (3) @(posedge ref_clk);
    chk("half flag cleared", irq, 32'h0);
    $display("tally test done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    test_regs();
    test_flags();
    test_tally();
    results();
  end
endmodule
